// *** serial_console_pkg.sv ***
// constants, types and timing figures shared by the serial console channel
package serial_console_pkg;

  // ----------------------------------------------------------------
  // clock and bit timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 10000000;
  localparam int unsigned OVERSAMPLE   = 16;
  localparam int unsigned OVS_HALF     = OVERSAMPLE / 2;
  localparam int unsigned DIV_W        = 12;

  // ----------------------------------------------------------------
  // character format
  // ----------------------------------------------------------------
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned STOP_BITS    = 2;
  localparam int unsigned FRAME_BITS   = 1 + DATA_BITS + STOP_BITS;
  localparam int unsigned BIT_CNT_W    = 4;

  // ----------------------------------------------------------------
  // rate select codes, 0 to 6; the rest fall back to the slowest rate
  // ----------------------------------------------------------------
  localparam logic [2:0] RATE_300   = 3'h0;
  localparam logic [2:0] RATE_600   = 3'h1;
  localparam logic [2:0] RATE_1200  = 3'h2;
  localparam logic [2:0] RATE_2400  = 3'h3;
  localparam logic [2:0] RATE_4800  = 3'h4;
  localparam logic [2:0] RATE_9600  = 3'h5;
  localparam logic [2:0] RATE_19200 = 3'h6;

  // oversample tick divisor for a given rate, rounded down, at least one
  function automatic logic [DIV_W-1:0] tick_div(input int unsigned bps);
    int unsigned d;
    d = CLK_HZ / (bps * OVERSAMPLE);
    if (d < 1) begin
      d = 1;
    end
    return d[DIV_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // software flow control
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAR_XOFF     = 8'h13;
  localparam logic [7:0] CHAR_XON      = 8'h11;
  localparam int unsigned BUF_DEPTH    = 128;
  localparam int unsigned BUF_AW       = 7;
  localparam logic [BUF_AW:0] LVL_HIGH = 8'h40;   // half of 128
  localparam logic [BUF_AW:0] LVL_LOW  = 8'h2c;   // 35 percent of 128

  // transmitter states
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } tx_state_type;

endpackage

// *** serial_rx.sv ***
// receiver: oversampled start detect, centre sampling, two stop bits
`timescale 1ns/1ps
module serial_rx (
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   srst_i,
  // oversample tick and line
  input  wire logic                   tick_i,
  input  wire logic                   line_i,
  input  wire logic                   enable_i,
  // received character
  output logic      [7:0]             data_o,
  output logic                        valid_o,
  output logic                        frame_err_o
);

  logic [3:0]                              phase_r;
  logic [serial_console_pkg::BIT_CNT_W-1:0] bit_r;
  logic [7:0]                              shift_r;
  logic                                    busy_r;
  logic                                    stop_ok_r;

  // line is held high (idle) when the port is disabled
  wire line_eff = line_i | ~enable_i;
  wire centre   = tick_i && (phase_r == 4'(serial_console_pkg::OVS_HALF - 1));
  wire last_bit = (bit_r == 4'(serial_console_pkg::FRAME_BITS - 1));

  // sample each bit at the centre of its oversampled cell
  always_ff @(posedge clk_sys_i) begin
    valid_o     <= 1'b0;
    frame_err_o <= 1'b0;
    if (srst_i) begin
      phase_r   <= 4'h0;
      bit_r     <= '0;
      shift_r   <= 8'h00;
      busy_r    <= 1'b0;
      stop_ok_r <= 1'b1;
      data_o    <= 8'h00;
    end else if (!busy_r) begin
      if (tick_i && !line_eff) begin
        busy_r    <= 1'b1;
        phase_r   <= 4'h1;
        bit_r     <= '0;
        stop_ok_r <= 1'b1;
      end
    end else if (tick_i) begin
      phase_r <= phase_r + 4'h1;
      if (centre) begin
        bit_r <= bit_r + 4'h1;
        if (bit_r == '0 && line_eff) begin
          busy_r <= 1'b0;                           // glitch, not a start
        end else if (bit_r >= 4'h1 && bit_r <= 4'(serial_console_pkg::DATA_BITS)) begin
          shift_r <= {line_eff, shift_r[7:1]};
        end else if (bit_r > 4'(serial_console_pkg::DATA_BITS)) begin
          stop_ok_r <= stop_ok_r & line_eff;
          if (last_bit) begin
            busy_r      <= 1'b0;
            valid_o     <= stop_ok_r & line_eff;
            frame_err_o <= ~(stop_ok_r & line_eff);
            data_o      <= {1'b0, shift_r[6:0]};
          end
        end
      end
    end
  end

endmodule

// *** serial_console_channel.sv ***
// serial console channel: role swap, rate select, hardware or software flow
`timescale 1ns/1ps
// How it works
// - 8 data bits, no parity, 2 stop bits; top bit sent 0, read as 0.
// - rate select picks 300 up to 19200 bits per second.
// - role input picks terminal or modem; each line pair swaps direction.
// - terminal drives TxD, samples RxD; modem drives RxD, samples TxD.
// - DSR tells terminal modem ready; DTR tells modem terminal ready.
// - ready lines held on; in hardware mode nothing moves while the peer's is off.
// - RTS from terminal says terminal can take data.
// - CTS from modem says modem can take data.
// - dynamic lines pace each character; static lines show unit is alive.
// - two flow methods: per-character hardware, block-wise software.
// - with only data and ground wired, software flow alone is used.
// - with handshake lines wired, every transfer is hardware paced.
// - as modem in hardware mode, send only while RTS and DTR on.
// - software mode sends XOFF when 128-byte buffer reaches half.
// - after XOFF, send XON when buffer drains to 35 percent.
module serial_console_channel (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  // configuration
  input  wire logic       modem_role_i,      // 1 modem, 0 terminal
  input  wire logic       hw_flow_i,         // 1 hardware, 0 software
  input  wire logic [2:0] rate_sel_i,
  // line side inputs (sampled per role)
  input  wire logic       txd_line_i,
  input  wire logic       rxd_line_i,
  input  wire logic       dtr_line_i,
  input  wire logic       dsr_line_i,
  input  wire logic       rts_line_i,
  input  wire logic       cts_line_i,
  // line side outputs with enables (per role)
  output logic            txd_line_o,
  output logic            txd_oe_o,
  output logic            rxd_line_o,
  output logic            rxd_oe_o,
  output logic            dtr_line_o,
  output logic            dtr_oe_o,
  output logic            dsr_line_o,
  output logic            dsr_oe_o,
  output logic            rts_line_o,
  output logic            rts_oe_o,
  output logic            cts_line_o,
  output logic            cts_oe_o,
  // user transmit side
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  // user receive side (reads drain the buffer)
  input  wire logic       rx_ready_i,
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_frame_err_o,
  output logic            rx_overrun_o
);

  // ----------------------------------------------------------------
  // rate generator
  // ----------------------------------------------------------------
  logic [serial_console_pkg::DIV_W-1:0] div_r;
  logic [serial_console_pkg::DIV_W-1:0] div_sel;
  logic                                 tick_r;

  // rate table, unused codes take the slowest rate
  always_comb begin
    case (rate_sel_i)
      serial_console_pkg::RATE_600:   div_sel = serial_console_pkg::tick_div(600);
      serial_console_pkg::RATE_1200:  div_sel = serial_console_pkg::tick_div(1200);
      serial_console_pkg::RATE_2400:  div_sel = serial_console_pkg::tick_div(2400);
      serial_console_pkg::RATE_4800:  div_sel = serial_console_pkg::tick_div(4800);
      serial_console_pkg::RATE_9600:  div_sel = serial_console_pkg::tick_div(9600);
      serial_console_pkg::RATE_19200: div_sel = serial_console_pkg::tick_div(19200);
      default:                        div_sel = serial_console_pkg::tick_div(300);
    endcase
  end

  // oversample tick, one pulse per divisor period
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || div_r >= div_sel - 1'b1) begin
      div_r  <= '0;
      tick_r <= ~srst_i;
    end else begin
      div_r  <= div_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // role mapping of the three line pairs
  // ----------------------------------------------------------------
  wire ser_in    = modem_role_i ? txd_line_i : rxd_line_i;
  wire peer_rdy  = modem_role_i ? dtr_line_i : dsr_line_i;
  wire peer_take = modem_role_i ? rts_line_i : cts_line_i;
  // handshake lines only matter when wired, i.e. hardware mode
  wire link_up   = !hw_flow_i || peer_rdy;
  wire hw_go     = peer_rdy && peer_take;

  // ----------------------------------------------------------------
  // receiver and 128-entry buffer
  // ----------------------------------------------------------------
  logic [7:0] rx_char;
  logic       rx_got;
  logic       rx_ferr;

  serial_rx u_rx (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .tick_i      (tick_r),
    .line_i      (ser_in),
    .enable_i    (link_up),
    .data_o      (rx_char),
    .valid_o     (rx_got),
    .frame_err_o (rx_ferr)
  );

  logic [7:0]                          buf_mem [serial_console_pkg::BUF_DEPTH];
  logic [serial_console_pkg::BUF_AW-1:0] wp_r;
  logic [serial_console_pkg::BUF_AW-1:0] rp_r;
  logic [serial_console_pkg::BUF_AW:0]   lvl_r;
  logic                                 peer_paused_r;  // XOFF seen from peer
  logic                                 we_paused_r;    // we sent XOFF

  wire is_xoff  = rx_got && !hw_flow_i && rx_char == serial_console_pkg::CHAR_XOFF;
  wire is_xon   = rx_got && !hw_flow_i && rx_char == serial_console_pkg::CHAR_XON;
  wire buf_full = lvl_r == (serial_console_pkg::BUF_AW+1)'(serial_console_pkg::BUF_DEPTH);
  wire wr_en    = rx_got && !is_xoff && !is_xon && !buf_full;
  wire rd_en    = rx_valid_o && rx_ready_i;
  wire buf_nonempty = (lvl_r != '0);

  // buffer storage and occupancy
  always_ff @(posedge clk_sys_i) begin
    if (wr_en) begin
      buf_mem[wp_r] <= rx_char;
    end
    if (srst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      lvl_r <= '0;
    end else begin
      wp_r  <= wp_r + (serial_console_pkg::BUF_AW)'(wr_en);
      rp_r  <= rp_r + (serial_console_pkg::BUF_AW)'(rd_en);
      lvl_r <= lvl_r + (serial_console_pkg::BUF_AW+1)'(wr_en)
                     - (serial_console_pkg::BUF_AW+1)'(rd_en);
    end
  end

  // read port registered, present head while not empty, except the cycle after a read
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rx_valid_o     <= 1'b0;
      rx_data_o      <= 8'h00;
      rx_frame_err_o <= 1'b0;
      rx_overrun_o   <= 1'b0;
    end else begin
      rx_valid_o     <= buf_nonempty && !rd_en && !(lvl_r == 1 && rd_en);
      rx_data_o      <= buf_mem[rd_en ? rp_r + 1'b1 : rp_r];
      rx_frame_err_o <= rx_ferr;
      rx_overrun_o   <= rx_got && buf_full;
    end
  end

  // ----------------------------------------------------------------
  // software flow state
  // ----------------------------------------------------------------
  logic xoff_due;
  logic xon_due;
  assign xoff_due = !hw_flow_i && !we_paused_r && lvl_r >= serial_console_pkg::LVL_HIGH;
  assign xon_due  = !hw_flow_i && we_paused_r && lvl_r <= serial_console_pkg::LVL_LOW;

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  serial_console_pkg::tx_state_type st_r;
  logic [3:0]                              ph_r;
  logic [serial_console_pkg::BIT_CNT_W-1:0] bc_r;
  logic [7:0]                              sh_r;
  logic                                    ser_out_r;
  logic                                    ctl_pending_r;

  wire bit_end  = tick_r && ph_r == 4'(serial_console_pkg::OVERSAMPLE - 1);
  wire send_ok  = hw_flow_i ? hw_go : !peer_paused_r;
  wire ctl_go   = st_r == serial_console_pkg::TX_IDLE && (xoff_due || xon_due) && link_up;
  wire user_go  = st_r == serial_console_pkg::TX_IDLE && !ctl_go && tx_valid_i
                  && send_ok && link_up;

  // flow flags, set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || hw_flow_i) begin
      peer_paused_r <= 1'b0;
      we_paused_r   <= 1'b0;
    end else begin
      if (is_xoff) begin
        peer_paused_r <= 1'b1;
      end else if (is_xon) begin
        peer_paused_r <= 1'b0;
      end
      if (ctl_go) begin
        we_paused_r <= xoff_due;
      end
    end
  end

  // frame shifter: start, 8 data lsb first, 2 stop
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r      <= serial_console_pkg::TX_IDLE;
      ph_r      <= 4'h0;
      bc_r      <= '0;
      sh_r      <= 8'h00;
      ser_out_r <= 1'b1;
    end else begin
      ph_r <= tick_r ? ph_r + 4'h1 : ph_r;
      case (st_r)
        serial_console_pkg::TX_IDLE: begin
          ser_out_r <= 1'b1;
          if (ctl_go || user_go) begin
            sh_r <= ctl_go ? (xoff_due ? serial_console_pkg::CHAR_XOFF
                                       : serial_console_pkg::CHAR_XON)
                           : {1'b0, tx_data_i[6:0]};
            st_r <= serial_console_pkg::TX_START;
            ph_r <= 4'h0;
          end
        end
        serial_console_pkg::TX_START: begin
          ser_out_r <= 1'b0;
          if (bit_end) begin
            st_r <= serial_console_pkg::TX_DATA;
            bc_r <= '0;
          end
        end
        serial_console_pkg::TX_DATA: begin
          ser_out_r <= sh_r[0];
          if (bit_end) begin
            sh_r <= {1'b1, sh_r[7:1]};
            bc_r <= bc_r + 4'h1;
            if (bc_r == 4'(serial_console_pkg::DATA_BITS - 1)) begin
              st_r <= serial_console_pkg::TX_STOP;
              bc_r <= '0;
            end
          end
        end
        serial_console_pkg::TX_STOP: begin
          ser_out_r <= 1'b1;
          if (bit_end) begin
            bc_r <= bc_r + 4'h1;
            if (bc_r == 4'(serial_console_pkg::STOP_BITS - 1)) begin
              st_r <= serial_console_pkg::TX_IDLE;
            end
          end
        end
        default: st_r <= serial_console_pkg::TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registered pin drivers, role picks which pin of each pair is driven
  // ----------------------------------------------------------------
  wire own_take = hw_flow_i ? !buf_nonempty : 1'b1;   // per-character grant
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      txd_line_o <= 1'b1;
      rxd_line_o <= 1'b1;
      dtr_line_o <= 1'b0;
      dsr_line_o <= 1'b0;
      rts_line_o <= 1'b0;
      cts_line_o <= 1'b0;
      txd_oe_o   <= 1'b0;
      rxd_oe_o   <= 1'b0;
      dtr_oe_o   <= 1'b0;
      dsr_oe_o   <= 1'b0;
      rts_oe_o   <= 1'b0;
      cts_oe_o   <= 1'b0;
      tx_ready_o <= 1'b0;
    end else begin
      txd_oe_o   <= !modem_role_i;
      rxd_oe_o   <= modem_role_i;
      dtr_oe_o   <= !modem_role_i;
      dsr_oe_o   <= modem_role_i;
      rts_oe_o   <= !modem_role_i;
      cts_oe_o   <= modem_role_i;
      txd_line_o <= ser_out_r;
      rxd_line_o <= ser_out_r;
      dtr_line_o <= 1'b1;
      dsr_line_o <= 1'b1;
      rts_line_o <= own_take;
      cts_line_o <= own_take;
      tx_ready_o <= user_go;                          // one-cycle accept pulse
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_tx_gated: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    user_go && hw_flow_i |-> peer_rdy && peer_take)
    else $error("character started without hardware grant");
  a_xoff_level: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ctl_go && xoff_due |=> sh_r == serial_console_pkg::CHAR_XOFF)
    else $error("xoff not loaded");
  a_msb_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(st_r == serial_console_pkg::TX_START) && !$past(ctl_go) |-> sh_r[7] == 1'b0)
    else $error("top data bit sent as one");
  a_ready_held: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $past(!srst_i) |-> dtr_line_o && dsr_line_o)
    else $error("ready line dropped");
  a_role_oe: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $stable(modem_role_i) && !$past(srst_i) |-> txd_oe_o != rxd_oe_o)
    else $error("both data pins driven");
  a_xon_after: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    xon_due |-> we_paused_r && lvl_r <= serial_console_pkg::LVL_LOW)
    else $error("xon without pause");
  a_rx_stop: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rx_got |-> !rx_ferr && rx_char[7] == 1'b0)
    else $error("bad character accepted");
  a_link_down: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    hw_flow_i && !peer_rdy |-> !user_go && !ctl_go)
    else $error("transfer with ready low");
  c_hw_send: cover property (@(posedge clk_sys_i) user_go && hw_flow_i);
  c_sw_xoff: cover property (@(posedge clk_sys_i) ctl_go && xoff_due);
  c_sw_xon:  cover property (@(posedge clk_sys_i) ctl_go && xon_due);
  c_rx_char: cover property (@(posedge clk_sys_i) wr_en);

endmodule

// *** console_peer.sv ***
// far-side console peer: serial sender, centre-sampling receiver, ready lines
`timescale 1ns/1ps
module console_peer #(
  parameter int BIT_CYC = 512
) (
  // clock
  input  wire logic clk_sys_i,
  // data lines
  input  wire logic from_dut_i,
  output logic      to_dut_o,
  // handshake lines: static ready and per-character take
  output logic      ready_o,
  output logic      take_o
);
  // lines idle at mark and ready until a test says otherwise
  initial begin
    to_dut_o = 1'b1;
    ready_o  = 1'b1;
    take_o   = 1'b1;
  end

  // handshake lines change just after an edge
  task automatic set_lines(input logic rdy, input logic take);
    @(posedge clk_sys_i);
    #10;
    ready_o = rdy;
    take_o  = take;
  endtask

  // start, 8 data lsb first, two stops; bad_stop pulls the first stop low
  task automatic send(input logic [7:0] ch, input logic bad_stop);
    logic [10:0] frame;
    frame = {1'b1, ~bad_stop, ch, 1'b0};
    @(posedge clk_sys_i);
    #10;
    for (int i = 0; i < 11; i++) begin
      to_dut_o = frame[i];
      repeat (BIT_CYC) @(posedge clk_sys_i);
      #10;
    end
  endtask

  // bounded wait for a start bit, then sample each bit at its centre
  task automatic recv(output logic [7:0] ch, output logic stops, output logic seen);
    int n;
    n = 0;
    while (from_dut_i !== 1'b0 && n < 40 * BIT_CYC) begin
      @(posedge clk_sys_i);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge clk_sys_i);
    seen = (from_dut_i === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_sys_i);
      ch[i] = from_dut_i;
    end
    stops = 1'b1;
    for (int i = 0; i < 2; i++) begin
      repeat (BIT_CYC) @(posedge clk_sys_i);
      stops = stops & from_dut_i;
    end
  endtask
endmodule

// *** testbench.sv ***
// testbench for the serial console channel: roles, format, flow control
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  // ----------------------------------------------------------------
  // stimulus and bookkeeping
  // ----------------------------------------------------------------
  localparam int BIT_CYC = 512;  // 16 ticks of 32 clocks at 19200
  logic       clk_sys_i    = 1'b0;
  logic       srst_i       = 1'b1;
  logic       modem_role_i = 1'b1;
  logic       hw_flow_i    = 1'b0;
  logic [2:0] rate_sel_i   = serial_console_pkg::RATE_19200;
  logic [7:0] tx_data_i    = 8'h00;
  logic       tx_valid_i   = 1'b0;
  logic       rx_ready_i   = 1'b0;
  int         errors       = 0;
  int         checks_done  = 0;
  int         ferr_count   = 0;
  logic txd_line_o, txd_oe_o, rxd_line_o, rxd_oe_o, dtr_line_o, dtr_oe_o;
  logic dsr_line_o, dsr_oe_o, rts_line_o, rts_oe_o, cts_line_o, cts_oe_o;
  logic tx_ready_o, rx_valid_o, rx_frame_err_o, rx_overrun_o;
  logic [7:0] rx_data_o;
  wire logic  peer_data, peer_ready, peer_take;

  // ----------------------------------------------------------------
  // wire levels: whoever enables drives, an undriven data line idles at mark
  // ----------------------------------------------------------------
  wire logic txd_pin = txd_oe_o === 1'b1 ? txd_line_o : (modem_role_i ? peer_data : 1'b1);
  wire logic rxd_pin = rxd_oe_o === 1'b1 ? rxd_line_o : (modem_role_i ? 1'b1 : peer_data);
  wire logic dtr_pin = dtr_oe_o === 1'b1 ? dtr_line_o : peer_ready;
  wire logic dsr_pin = dsr_oe_o === 1'b1 ? dsr_line_o : peer_ready;
  wire logic rts_pin = rts_oe_o === 1'b1 ? rts_line_o : peer_take;
  wire logic cts_pin = cts_oe_o === 1'b1 ? cts_line_o : peer_take;
  wire logic dut_pin = modem_role_i ? rxd_pin : txd_pin;
  wire logic take_line = modem_role_i ? cts_line_o : rts_line_o;

  always #50 clk_sys_i = ~clk_sys_i;

  // frame error is a one-cycle pulse, so count it as it passes
  always @(posedge clk_sys_i) if (rx_frame_err_o === 1'b1) ferr_count++;

  serial_console_channel dut_u (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .modem_role_i(modem_role_i),
    .hw_flow_i(hw_flow_i), .rate_sel_i(rate_sel_i),
    .txd_line_i(txd_pin), .rxd_line_i(rxd_pin), .dtr_line_i(dtr_pin),
    .dsr_line_i(dsr_pin), .rts_line_i(rts_pin), .cts_line_i(cts_pin),
    .txd_line_o(txd_line_o), .txd_oe_o(txd_oe_o), .rxd_line_o(rxd_line_o),
    .rxd_oe_o(rxd_oe_o), .dtr_line_o(dtr_line_o), .dtr_oe_o(dtr_oe_o),
    .dsr_line_o(dsr_line_o), .dsr_oe_o(dsr_oe_o), .rts_line_o(rts_line_o),
    .rts_oe_o(rts_oe_o), .cts_line_o(cts_line_o), .cts_oe_o(cts_oe_o),
    .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .rx_frame_err_o(rx_frame_err_o), .rx_overrun_o(rx_overrun_o)
  );

  console_peer #(.BIT_CYC(BIT_CYC)) peer_u (
    .clk_sys_i(clk_sys_i), .from_dut_i(dut_pin), .to_dut_o(peer_data),
    .ready_o(peer_ready), .take_o(peer_take)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic test_end(input string name);
    $display("test %s finished, mismatches so far %0d", name, errors);
  endtask

  // role and flow only change under reset, so the line pairs never glitch
  task automatic do_reset(input logic role, input logic hw);
    @(posedge clk_sys_i);
    #10;
    srst_i = 1'b1;
    modem_role_i = role;
    hw_flow_i = hw;
    repeat (4) @(posedge clk_sys_i);
    #10;
    `CHECK_EQ({txd_oe_o, rxd_oe_o, dsr_oe_o, cts_oe_o}, 4'h0)
    srst_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #10;
    if (role) begin
      `CHECK_EQ({rxd_oe_o, dsr_oe_o, cts_oe_o, txd_oe_o, dtr_oe_o, rts_oe_o}, 6'h38)
      `CHECK_EQ({dsr_line_o, rxd_line_o}, 2'h3)
    end else begin
      `CHECK_EQ({rxd_oe_o, dsr_oe_o, cts_oe_o, txd_oe_o, dtr_oe_o, rts_oe_o}, 6'h07)
      `CHECK_EQ({dtr_line_o, txd_line_o}, 2'h3)
    end
  endtask

  // hold the character offered until tx_ready_o pulses, then check what the peer receives
  task automatic dut_send(input logic [7:0] ch);
    logic [7:0] got;
    logic       stops;
    logic       seen;
    int         n;
    n = 0;
    fork
      peer_u.recv(got, stops, seen);
      begin
        tx_data_i = ch;
        tx_valid_i = 1'b1;
        while (tx_ready_o !== 1'b1 && n < 33 * BIT_CYC) begin
          @(posedge clk_sys_i);
          #10;
          n++;
        end
        @(posedge clk_sys_i);
        #10;
        tx_valid_i = 1'b0;
      end
    join
    `CHECK_EQ(n < 33 * BIT_CYC, 1'b1)
    `CHECK_EQ(seen, 1'b1)
    `CHECK_EQ(got, {1'b0, ch[6:0]})
    `CHECK_EQ(stops, 1'b1)
  endtask

  // peer sends one character; in hardware mode the take line must drop until it is popped
  task automatic peer_to_dut(input logic [7:0] ch, input logic hw);
    int n;
    n = 0;
    peer_u.send(ch, 1'b0);
    while (rx_valid_o !== 1'b1 && n < BIT_CYC) begin
      @(posedge clk_sys_i);
      n++;
    end
    #10;
    `CHECK_EQ(rx_data_o, {1'b0, ch[6:0]})
    if (hw) begin
      `CHECK_EQ(take_line, 1'b0)
    end
    rx_ready_i = 1'b1;
    @(posedge clk_sys_i);
    #10;
    rx_ready_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #10;
    `CHECK_EQ({rx_valid_o, take_line, rx_overrun_o}, 3'h2)
  endtask

  // an offered character must not leave while a peer line is off
  task automatic blocked(input logic rdy, input logic take);
    int lows;
    lows = 0;
    peer_u.set_lines(rdy, take);
    tx_data_i = 8'h5a;
    tx_valid_i = 1'b1;
    repeat (2 * BIT_CYC) begin
      @(posedge clk_sys_i);
      if (rxd_pin !== 1'b1) lows++;
    end
    #10;
    `CHECK_EQ(lows, 0)
    tx_valid_i = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    do_reset(1'b1, 1'b0);
    peer_u.set_lines(1'b0, 1'b0);
    dut_send(8'hc5);
    peer_to_dut(8'ha3, 1'b0);
    peer_u.send(serial_console_pkg::CHAR_XOFF, 1'b0);
    blocked(1'b1, 1'b1);
    peer_u.send(serial_console_pkg::CHAR_XON, 1'b0);
    `CHECK_EQ(rx_valid_o, 1'b0)
    dut_send(8'h9b);
    peer_u.send(8'h55, 1'b1);
    repeat (4) @(posedge clk_sys_i);
    `CHECK_EQ(ferr_count, 1)
    test_end("modem software flow");
    do_reset(1'b1, 1'b1);
    blocked(1'b0, 1'b1);
    blocked(1'b1, 1'b0);
    peer_u.set_lines(1'b1, 1'b1);
    dut_send(8'h3c);
    peer_to_dut(8'h7e, 1'b1);
    test_end("modem hardware flow");
    do_reset(1'b0, 1'b1);
    dut_send(8'hff);
    peer_to_dut(8'h80, 1'b1);
    test_end("terminal hardware flow");
    test_done();
  end

  // watchdog: the tests need about 60000 cycles
  initial begin
    repeat (80000) @(posedge clk_sys_i);
    errors++;
    test_done();
  end
endmodule
